//--- pkg/pin_task_event_pkg.sv
// Purpose: Shared constants and types for the pin task/event channel block
// Assumes: Avalon-MM register access with 32-bit words, byte addresses
// Notes:   Field layout follows the channel configuration word

package pin_task_event_pkg;

  localparam int          NUM_CHANNELS  = 8;
  localparam int          NUM_PINS      = 32;
  localparam int          ADDR_W        = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_INT_STATUS = 12'h100;
  localparam logic [11:0] OFS_INTEN      = 12'h300;
  localparam logic [11:0] OFS_INTEN_SET  = 12'h304;
  localparam logic [11:0] OFS_INTEN_CLR  = 12'h308;
  localparam logic [11:0] OFS_TASK_DRIVE = 12'h000;
  localparam logic [11:0] OFS_TASK_SET   = 12'h030;
  localparam logic [11:0] OFS_TASK_CLR   = 12'h060;
  localparam logic [11:0] OFS_CONFIG     = 12'h510;
  localparam logic [11:0] OFS_CONFIG_END = 12'h52C;

  // Configuration word fields
  localparam int          MODE_LSB      = 0;
  localparam int          PSEL_LSB      = 8;
  localparam int          SEL_LSB       = 16;
  localparam int          INIT_BIT      = 20;
  localparam logic [31:0] CONFIG_MASK   = 32'h00131F03;
  localparam logic [31:0] CONFIG_RESET  = 32'h00000000;

  // Mode encodings
  localparam logic [1:0]  MODE_DISABLED = 2'h0;
  localparam logic [1:0]  MODE_EVENT    = 2'h1;
  localparam logic [1:0]  MODE_TASK     = 2'h3;

  // Action / edge selection encodings
  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam logic [1:0]  SEL_RISING    = 2'h1;
  localparam logic [1:0]  SEL_FALLING   = 2'h2;
  localparam logic [1:0]  SEL_TOGGLE    = 2'h3;

  typedef struct packed {
    logic       initial_output_level;
    logic [1:0] selection;
    logic [4:0] pin_select;
    logic [1:0] mode;
  } channel_cfg_s;

  // Pin bundle toward the pad / GPIO mux
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] own;
  } pin_drive_s;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DONE
  } bus_state_e;

endpackage

//--- hdl/pin_task_event_unit.sv
// Purpose: Eight pin task/event channels with Avalon-MM registers
// Assumes: Pins and GPIO output request are synchronous to core_clk
// Notes:   Every access answers with waitrequest high for one cycle

`timescale 1ns/1ps

// What this block does
// - Eight independent channels each governed by its own configuration word.
// - Mode 0 leaves the selected pin untouched under ordinary I/O control.
// - Mode 1 makes the pin an input and raises the channel event on the selected transition.
// - Mode 3 makes the selected pin an output driven by the channel's tasks.
// - In task mode the drive task applies the operation that the action selection encodes.
// - In task mode the channel owns the pin and ordinary I/O writes have no effect on it.
// - The pin select field picks which of pins 0 to 31 the channel acts on.
// - Task action codes: 0 nothing, 1 high, 2 low, 3 invert.
// - Event edge codes: 0 never, 1 rising, 2 falling, 3 any change.
// - The initial level bit sets the pin level on entering task mode and is ignored in event mode.
// - Interrupt enable set and clear words enable or disable each channel event and read back the state.
module pin_task_event_unit
  import pin_task_event_pkg::*;
#(
  parameter int N_CH = pin_task_event_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  // Avalon-MM slave
  input  wire logic [pin_task_event_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic      [31:0]                        avs_readdata,
  output logic                                    avs_waitrequest,
  // Pins
  input  wire logic [31:0]                        pin_in,
  input  wire logic [31:0]                        gpio_out,
  input  wire logic [31:0]                        gpio_oe,
  output logic      [31:0]                        pin_out,
  output logic      [31:0]                        pin_oe,
  output logic      [31:0]                        pin_owned,
  // Events and interrupt
  output logic      [N_CH-1:0]                    pin_event,
  output logic                                    irq
);

  import pin_task_event_pkg::*;

  initial begin
    if (N_CH < 1 || N_CH > 32) begin
      $error("N_CH must be 1 to 32");
    end
  end

  typedef struct packed {
    bus_state_e                  bus;
    logic [31:0]                 rdata;
    channel_cfg_s [N_CH-1:0]     cfg;
    logic [N_CH-1:0]             level;
    logic [N_CH-1:0]             prev_in;
    logic [N_CH-1:0]             evt;
    logic [N_CH-1:0]             status;
    logic [N_CH-1:0]             inten;
    pin_drive_s                  drive;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic   rst_meta_reg;
  logic   rst_sync_n_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic        acc;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic        cur_in;
    logic        rise;
    logic        fall;
    logic [N_CH-1:0] read_clr;
    logic [11:0] ch_ofs;
    acc        = 1'b0;
    wr         = 1'b0;
    wmask      = 32'h00000000;
    wval       = 32'h00000000;
    cur_in     = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    read_clr   = '0;
    ch_ofs     = 12'h000;
    state_next = state_reg;
    // Reads are captured in the first cycle so the data stands when waitrequest drops
    acc        = (avs_read || avs_write) && (state_reg.bus == BUS_IDLE);
    // Writes land only at the edge where waitrequest is low, as the master expects
    // Taking them earlier would let a write act before the bus has accepted it
    wr         = avs_write && (state_reg.bus == BUS_DONE);
    wmask      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wval       = avs_writedata & wmask;

    // Bus handshake: one wait cycle then answer
    unique case (state_reg.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_next.bus = BUS_DONE;
        end
      end
      BUS_DONE: begin
        state_next.bus = BUS_IDLE;
      end
    endcase

    // Read data capture; unmapped addresses read zero
    if (acc && avs_read) begin
      state_next.rdata = 32'h00000000;
      if (avs_address == OFS_INTEN || avs_address == OFS_INTEN_SET || avs_address == OFS_INTEN_CLR) begin
        state_next.rdata[N_CH-1:0] = state_reg.inten;
      end else if (avs_address == OFS_INT_STATUS) begin
        state_next.rdata[N_CH-1:0] = state_reg.status;
        read_clr = state_reg.status;
      end else if (avs_address >= OFS_CONFIG && avs_address <= OFS_CONFIG_END && avs_address[1:0] == 2'h0) begin
        ch_ofs = avs_address - OFS_CONFIG;
        if (ch_ofs[11:2] < 10'(N_CH)) begin
          state_next.rdata = 32'(state_reg.cfg[ch_ofs[4:2]].mode) << MODE_LSB
                           | 32'(state_reg.cfg[ch_ofs[4:2]].pin_select) << PSEL_LSB
                           | 32'(state_reg.cfg[ch_ofs[4:2]].selection) << SEL_LSB
                           | 32'(state_reg.cfg[ch_ofs[4:2]].initial_output_level) << INIT_BIT;
        end
      end
    end

    if (wr && avs_address == OFS_INTEN) begin
      state_next.inten = wval[N_CH-1:0];
    end
    if (wr && avs_address == OFS_INTEN_SET) begin
      state_next.inten = state_reg.inten | wval[N_CH-1:0];
    end
    if (wr && avs_address == OFS_INTEN_CLR) begin
      state_next.inten = state_reg.inten & ~wval[N_CH-1:0];
    end

    state_next.evt = '0;
    for (int n = 0; n < N_CH; n++) begin
      if (wr && avs_address == OFS_CONFIG + 12'(4 * n)) begin
        state_next.cfg[n] = channel_cfg_s'({(avs_writedata[INIT_BIT] && avs_byteenable[2]) ?
                              1'b1 : (avs_byteenable[2] ? 1'b0 : state_reg.cfg[n].initial_output_level),
                              avs_byteenable[2] ? avs_writedata[SEL_LSB +: 2] : state_reg.cfg[n].selection,
                              avs_byteenable[1] ? avs_writedata[PSEL_LSB +: 5] : state_reg.cfg[n].pin_select,
                              avs_byteenable[0] ? avs_writedata[MODE_LSB +: 2] : state_reg.cfg[n].mode});
        // Load initial level on task config
        if (state_next.cfg[n].mode == MODE_TASK) begin
          state_next.level[n] = state_next.cfg[n].initial_output_level;
        end
      end else if (state_reg.cfg[n].mode == MODE_TASK) begin
        if (wr && avs_address == OFS_TASK_DRIVE + 12'(4 * n) && avs_writedata[0]) begin
          unique case (state_reg.cfg[n].selection)
            SEL_NONE:    state_next.level[n] = state_reg.level[n];
            SEL_RISING:  state_next.level[n] = 1'b1;
            SEL_FALLING: state_next.level[n] = 1'b0;
            SEL_TOGGLE:  state_next.level[n] = ~state_reg.level[n];
          endcase
        end
        if (wr && avs_address == OFS_TASK_SET + 12'(4 * n) && avs_writedata[0]) begin
          state_next.level[n] = 1'b1;
        end
        if (wr && avs_address == OFS_TASK_CLR + 12'(4 * n) && avs_writedata[0]) begin
          state_next.level[n] = 1'b0;
        end
      end

      // Selected pin sample
      // The edge compares the pin in use now against its own earlier sample
      cur_in = pin_in[state_reg.cfg[n].pin_select];
      // History follows the pin selected for the next cycle
      // Hazard avoided: a new pin select would otherwise compare two different pins
      // and raise a false edge event right after reconfiguration
      state_next.prev_in[n] = pin_in[state_next.cfg[n].pin_select];
      rise = cur_in && !state_reg.prev_in[n];
      fall = !cur_in && state_reg.prev_in[n];
      if (state_reg.cfg[n].mode == MODE_EVENT) begin
        unique case (state_reg.cfg[n].selection)
          SEL_NONE:    state_next.evt[n] = 1'b0;
          SEL_RISING:  state_next.evt[n] = rise;
          SEL_FALLING: state_next.evt[n] = fall;
          SEL_TOGGLE:  state_next.evt[n] = rise || fall;
        endcase
      end
    end

    // Sticky status: new events win over read clear
    state_next.status = (state_reg.status & ~read_clr) | state_reg.evt;

    state_next.drive.out = gpio_out;
    state_next.drive.oe  = gpio_oe;
    state_next.drive.own = 32'h00000000;
    for (int n = 0; n < N_CH; n++) begin
      if (state_reg.cfg[n].mode == MODE_TASK) begin
        state_next.drive.out[state_reg.cfg[n].pin_select] = state_next.level[n];
        state_next.drive.oe[state_reg.cfg[n].pin_select]  = 1'b1;
        state_next.drive.own[state_reg.cfg[n].pin_select] = 1'b1;
      end else if (state_reg.cfg[n].mode == MODE_EVENT) begin
        state_next.drive.oe[state_reg.cfg[n].pin_select]  = 1'b0;
        state_next.drive.own[state_reg.cfg[n].pin_select] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_waitrequest = (avs_read || avs_write) && (state_reg.bus == BUS_IDLE);
  assign avs_readdata    = state_reg.rdata;
  assign pin_out         = state_reg.drive.out;
  assign pin_oe          = state_reg.drive.oe;
  assign pin_owned       = state_reg.drive.own;
  assign pin_event       = state_reg.evt;
  assign irq             = |(state_reg.status & state_reg.inten);

endmodule // pin_task_event_unit

//--- verification/pin_task_event_unit_asserts.sv
// Purpose: Port checks for the pin task/event unit
// Assumes: One clock, checks idle while rst_n is low
// Notes:   Bound to every instance of the unit
`timescale 1ns/1ps
module pin_task_event_unit_asserts
  import pin_task_event_pkg::*;
#(
  parameter int N_CH = 8
) (
  // Clock, reset and bus
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // Pins, events and interrupt
  input wire logic [31:0]       pin_in,
  input wire logic [31:0]       gpio_out,
  input wire logic [31:0]       gpio_oe,
  input wire logic [31:0]       pin_out,
  input wire logic [31:0]       pin_oe,
  input wire logic [31:0]       pin_owned,
  input wire logic [N_CH-1:0]   pin_event,
  input wire logic              irq
);
  logic any_ev;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Any channel event this cycle
  assign any_ev = |pin_event;
  // Bus answer: one wait cycle, then done
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  ////////////////////////////////////////
  a_wait_read: assert property ($rose(avs_read) |-> s_answer)
    else $error("read answer timing wrong");
  a_wait_write: assert property ($rose(avs_write) |-> s_answer)
    else $error("write answer timing wrong");
  a_free_out: assert property (((pin_out ^ $past(gpio_out)) & ~pin_owned & ~$past(pin_owned)) == 32'h0)
    else $error("free pin level not from gpio");
  a_free_oe: assert property (((pin_oe ^ $past(gpio_oe)) & ~pin_owned & ~$past(pin_owned)) == 32'h0)
    else $error("free pin enable not from gpio");
  a_task_hold: assert property (!$past(avs_write) && !$past(avs_write, 2) && !$past(avs_write, 3)
    |-> ((pin_out ^ $past(pin_out)) & pin_oe & pin_owned & $past(pin_owned)) == 32'h0)
    else $error("owned pin moved without a task");
  a_event_cause: assert property (any_ev |-> $past(pin_in) != $past(pin_in, 2)
    || $past(pin_in, 2) != $past(pin_in, 3) || $past(pin_in, 3) != $past(pin_in, 4))
    else $error("event without pin change");
  a_irq_rise: assert property ($rose(irq) |-> $past(any_ev) || $past(any_ev, 2) || $past(avs_write))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_read) || $past(avs_write))
    else $error("interrupt fell without access");
endmodule // pin_task_event_unit_asserts
bind pin_task_event_unit pin_task_event_unit_asserts #(.N_CH(N_CH)) i_chk (
  .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .pin_in, .gpio_out, .gpio_oe, .pin_out, .pin_oe,
  .pin_owned, .pin_event, .irq
);

//--- verification/pin_partner.sv
// Purpose: Pad model beside the unit
// Assumes: No pull on the pads
// Notes:   Released pads take the bench level
`timescale 1ns/1ps
module pin_partner (
  // From the unit and the bench
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_lvl,
  // Pad levels
  output logic      [31:0] pin_in
);
  // Driven pads follow the unit
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // pin_partner

//--- verification/pin_task_event_unit_tb.sv
// Purpose: Self-checking bench for the pin task/event unit
// Assumes: Pad model closes the loop
// Notes:   Random pins from a fixed seed
`timescale 1ns/1ps
module pin_task_event_unit_tb;
  import pin_task_event_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [ADDR_W-1:0] avs_address = 12'h0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       gpio_out = 32'h0;
  logic [31:0]       gpio_oe = 32'h0;
  logic [31:0]       ext_lvl = 32'h0;
  logic [31:0]       avs_readdata, pin_in, pin_out, pin_oe, pin_owned, rd, d;
  logic [7:0]        pin_event;
  logic              avs_waitrequest, irq, ini;
  int                error_cnt = 0;
  int                n_compared = 0;
  int                cycles = 0;
  int                ev_cnt = 0;
  int                e0, p, q;
  pin_task_event_unit i_dut (
    .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pin_in, .gpio_out,
    .gpio_oe, .pin_out, .pin_oe, .pin_owned, .pin_event, .irq
  );
  pin_partner i_pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);
  initial forever #25 core_clk = ~core_clk;
  // Event count and run limit
  always @(negedge core_clk) begin
    cycles++;
    if (pin_event[1] === 1'b1) ev_cnt++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    // Sample waitrequest and read data at the rising edge itself
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  function automatic logic [31:0] cfg(logic [1:0] m, logic [4:0] pn, logic [1:0] s, logic i);
    return {11'h0, i, 2'h0, s, 3'h0, pn, 6'h0, m};
  endfunction
  // Pad level after a drive task
  function automatic logic drv(logic [1:0] s, logic i);
    return (s == SEL_NONE) ? i : (s == SEL_TOGGLE) ? !i : (s == SEL_RISING);
  endfunction
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h56d7));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(3);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      bus(0, OFS_CONFIG + 12'(4 * i), 32'h0);
      check(rd, CONFIG_RESET);
      bus(1, OFS_CONFIG + 12'(4 * i), d);
      bus(0, OFS_CONFIG + 12'(4 * i), 32'h0);
      check(rd, d & CONFIG_MASK);
      bus(1, OFS_CONFIG + 12'(4 * i), 32'h0);
    end
    bus(0, 12'h200, 32'h0);
    check(rd, 32'h0);
    $display("registers done");
    p = $urandom_range(31);
    q = (p + 1) % 32;
    ini = 1'($urandom);
    gpio_out <= $urandom;
    gpio_oe <= $urandom;
    for (int s = 0; s < 4; s++) begin
      bus(1, OFS_CONFIG, cfg(MODE_TASK, 5'(p), 2'(s), ini));
      tick(2);
      check(32'(pin_out[p]), 32'(ini));
      check(32'(pin_oe[p]), 32'h1);
      gpio_out <= ~gpio_out;
      bus(1, OFS_TASK_DRIVE, 32'h1);
      tick(2);
      check(32'(pin_out[p]), 32'(drv(2'(s), ini)));
    end
    bus(1, OFS_TASK_SET, 32'h1);
    tick(2);
    check(32'(pin_out[p]), 32'h1);
    bus(1, OFS_TASK_CLR, 32'h1);
    tick(2);
    check(32'(pin_out[p]), 32'h0);
    bus(1, OFS_CONFIG, 32'h0);
    tick(2);
    check(pin_out, gpio_out);
    check(pin_oe, gpio_oe);
    $display("task mode done");
    for (int s = 0; s < 4; s++) begin
      bus(1, OFS_CONFIG + 12'h4, cfg(MODE_EVENT, 5'(q), 2'(s), 1'b1));
      tick(4);
      e0 = ev_cnt;
      check(32'(pin_oe[q]), 32'h0);
      @(posedge core_clk) ext_lvl[q] <= 1'b1;
      tick(5);
      @(posedge core_clk) ext_lvl[q] <= 1'b0;
      tick(5);
      check(ev_cnt - e0, 32'(s % 2 + s / 2));
    end
    $display("event mode done");
    bus(1, OFS_CONFIG + 12'h4, cfg(MODE_EVENT, 5'(q), SEL_RISING, 1'b0));
    tick(4);
    bus(0, OFS_INT_STATUS, 32'h0);
    bus(1, OFS_INTEN_SET, 32'h2);
    bus(0, OFS_INTEN, 32'h0);
    check(rd, 32'h2);
    check(32'(irq), 32'h0);
    @(posedge core_clk) ext_lvl[q] <= 1'b1;
    tick(5);
    check(32'(irq), 32'h1);
    bus(0, OFS_INT_STATUS, 32'h0);
    check(rd, 32'h2);
    tick(1);
    check(32'(irq), 32'h0);
    bus(1, OFS_INTEN_CLR, 32'h2);
    bus(0, OFS_INTEN, 32'h0);
    check(rd, 32'h0);
    @(posedge core_clk) ext_lvl[q] <= 1'b0;
    tick(2);
    @(posedge core_clk) ext_lvl[q] <= 1'b1;
    tick(5);
    check(32'(irq), 32'h0);
    $display("interrupt done");
    print_verdict();
  end
endmodule // pin_task_event_unit_tb
